// ### dv/scsi_dma_halt_and_interrupts_tb.sv
// self-checking bench for the scsi dma halt and interrupt block
`timescale 1ns/100ps
`default_nettype none
module scsi_dma_halt_and_interrupts_tb;
	import sdh_pkg::*;
	logic clk, rst, awvalid, awready, wvalid, wready, bvalid, bready;
	logic arvalid, arready, rvalid, rready, dma_request_output, rdy, irq, ack, oe, run, eop, bsy_o, sel_o;
	logic [7:0] awaddr, araddr, d;
	logic [31:0] wdata, rdata;
	logic [1:0] rresp, bresp, last_resp;
	sdh_scsi_t scsi;
	sdh_dma_t dma;
	int fails, n_tests;
	// short arbitration delay keeps the run brief
	sdh_core #(.ARB_CYC(4)) dut (
		.core_clk_in(clk), .reset_in(rst),
		.s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready),
		.s_axi_wdata_in(wdata), .s_axi_wstrb_in(4'hf), .s_axi_wvalid_in(wvalid),
		.s_axi_wready_out(wready), .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid),
		.s_axi_bready_in(bready), .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid),
		.s_axi_arready_out(arready), .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp),
		.s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready), .scsi_bus_in(scsi),
		.dma_ctl_in(dma), .dma_request_out(dma_request_output), .dma_ready_out(rdy), .irq_out(irq),
		.scsi_ack_out(ack), .scsi_data_oe_out(oe),
		.scsi_bsy_out(bsy_o), .scsi_sel_out(sel_o)
	);
	sdh_dma_model u_dma (
		.core_clk_in(clk), .reset_in(rst), .run_in(run), .eop_in(eop),
		.dma_request_in(dma_request_output), .dma_ctl_out(dma)
	);
	// 125 mhz clock
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_tests++;
		if (got !== exp) begin
			fails++;
			$display("ERROR %0t got %h expected %h", $time, got, exp);
		end
	endtask
	// address and data offered together, each dropped once taken
	task automatic w_reg(input logic [7:0] a, input logic [7:0] v);
		int n;
		n = 0;
		@(posedge clk);
		awaddr <= a;
		wdata <= {24'h0, v};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge clk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
			n++;
		end while (bvalid !== 1'b1 && n < 50);
		last_resp = bresp;
		if (bvalid !== 1'b1) begin
			fails++;
			$display("ERROR %0t write answer missing", $time);
		end
		bready <= 1'b0;
	endtask
	task automatic r_reg(input logic [7:0] a, output logic [7:0] v);
		int n;
		n = 0;
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge clk);
			if (arready) arvalid <= 1'b0;
			n++;
		end while (rvalid !== 1'b1 && n < 50);
		if (rvalid !== 1'b1) begin
			fails++;
			$display("ERROR %0t read answer missing", $time);
		end
		v = rdata[7:0];
		last_resp = rresp;
		rready <= 1'b0;
	endtask
	task automatic rc(input logic [7:0] a, input logic [7:0] exp);
		logic [7:0] v;
		r_reg(a, v);
		chk(v, exp);
	endtask
	// bounded wait for the interrupt level
	task automatic wirq(input logic v);
		int n;
		n = 0;
		while (irq !== v && n < 200) begin
			@(posedge clk);
			n++;
		end
		chk({7'h0, irq}, {7'h0, v});
	endtask
	task automatic close_out;
		$display("comparisons %0d mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	// watchdog, far beyond the few hundred cycles the tests need
	initial begin
		repeat (20000) @(posedge clk);
		fails++;
		close_out;
	end
	initial begin
		rst = 1'b1;
		{awvalid, wvalid, bready, arvalid, rready, run, eop} = 7'h00;
		awaddr = 8'h00;
		araddr = 8'h00;
		wdata = 32'h0;
		scsi = '0;
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		// cleared registers, unmapped place refused
		rc(OFS_INIT_CMD, 8'h00);
		rc(OFS_MODE2, 8'h00);
		chk({7'h0, irq}, 8'h00);
		rc(8'h20, 8'h00);
		chk({6'h0, last_resp}, {6'h0, RESP_SLVERR});
		w_reg(8'h20, 8'h00);
		chk({6'h0, last_resp}, {6'h0, RESP_SLVERR});
		// pseudo dma: poll the request, then act as controller with eop
		w_reg(OFS_TPHASE, 8'h01);
		scsi.io <= 1'b1;
		w_reg(OFS_MODE2, 8'h0a);
		scsi.req <= 1'b1;
		repeat (10) @(posedge clk);
		chk({7'h0, dma_request_output}, 8'h01);
		r_reg(OFS_BUS_STAT, d);
		chk(d & 8'h40, 8'h40);
		run <= 1'b1;
		eop <= 1'b1;
		wirq(1'b1);
		rc(OFS_MODE2, 8'h0a);
		chk({7'h0, ack}, 8'h01);
		r_reg(OFS_BUS_STAT, d);
		chk(d & 8'h80, 8'h80);
		{run, eop, scsi.req} <= 3'h0;
		repeat (8) @(posedge clk);
		w_reg(OFS_MODE2, 8'h00);
		repeat (4) @(posedge clk);
		chk({6'h0, ack, dma_request_output}, 8'h00);
		r_reg(OFS_HIGHEST, d);
		wirq(1'b0);
		// block mode: one request up front, then ready paces the bytes
		w_reg(OFS_MODE2, 8'h82);
		repeat (2) @(posedge clk);
		chk({6'h0, rdy, dma_request_output}, 8'h01);
		scsi.req <= 1'b1;
		repeat (6) @(posedge clk);
		chk({6'h0, rdy, dma_request_output}, 8'h02);
		scsi.req <= 1'b0;
		w_reg(OFS_MODE2, 8'h00);
		// compatible mismatch halts and drops the data drive
		w_reg(OFS_TPHASE, 8'h00);
		{scsi.io, scsi.cd} <= 2'b01;
		w_reg(OFS_INIT_CMD, 8'h01);
		w_reg(OFS_MODE2, 8'h02);
		repeat (2) @(posedge clk);
		chk({6'h0, oe, dma_request_output}, 8'h02);
		scsi.req <= 1'b1;
		wirq(1'b1);
		repeat (4) @(posedge clk);
		chk({6'h0, oe, dma_request_output}, 8'h00);
		scsi.req <= 1'b0;
		w_reg(OFS_MODE2, 8'h00);
		w_reg(OFS_INIT_CMD, 8'h00);
		r_reg(OFS_HIGHEST, d);
		wirq(1'b0);
		// enhanced: flagged mismatch, indexed status, clear, per-bit mask
		w_reg(OFS_INIT_CMD, 8'h40);
		scsi.req <= 1'b1;
		wirq(1'b1);
		w_reg(OFS_HIGHEST, 8'h06);
		rc(OFS_HIGHEST, 8'h08);
		scsi.req <= 1'b0;
		w_reg(OFS_HIGHEST, 8'h02);
		w_reg(OFS_HIGHEST, 8'h00);
		wirq(1'b0);
		w_reg(OFS_HIGHEST, 8'h06);
		w_reg(OFS_HIGHEST, 8'h08);
		scsi.req <= 1'b1;
		repeat (20) @(posedge clk);
		chk({7'h0, irq}, 8'h00);
		w_reg(OFS_HIGHEST, 8'h06);
		rc(OFS_HIGHEST, 8'h00);
		scsi.req <= 1'b0;
		w_reg(OFS_MODE2, 8'h02);
		scsi.req <= 1'b1;
		wirq(1'b1);
		w_reg(OFS_HIGHEST, 8'h06);
		rc(OFS_HIGHEST, 8'h10);
		scsi.req <= 1'b0;
		w_reg(OFS_MODE2, 8'h00);
		w_reg(OFS_HIGHEST, 8'h02);
		w_reg(OFS_HIGHEST, 8'h00);
		wirq(1'b0);
		// arbitration on a free bus with no higher id: won, busy and select driven
		w_reg(OFS_HIGHEST, 8'h01);
		wirq(1'b1);
		chk({6'h0, bsy_o, sel_o}, 8'h03);
		w_reg(OFS_HIGHEST, 8'h06);
		rc(OFS_HIGHEST, 8'h01);
		w_reg(OFS_HIGHEST, 8'h02);
		w_reg(OFS_HIGHEST, 8'h00);
		wirq(1'b0);
		w_reg(OFS_INIT_CMD, 8'h00);
		// compatible busy loss, not before the settle delay
		scsi.bsy <= 1'b1;
		w_reg(OFS_MODE2, 8'h04);
		scsi.bsy <= 1'b0;
		repeat (30) @(posedge clk);
		chk({7'h0, irq}, 8'h00);
		wirq(1'b1);
		w_reg(OFS_MODE2, 8'h00);
		r_reg(OFS_HIGHEST, d);
		wirq(1'b0);
		close_out;
	end
endmodule
`default_nettype wire

// ### dv/sdh_core_asserts.sv
// port checks for the scsi dma halt and interrupt block
`timescale 1ns/100ps
`default_nettype none
module sdh_core_asserts #(
	parameter int ARB_CYC = sdh_pkg::ARB_DLY_CYC
) (
	input wire logic core_clk_in,
	input wire logic reset_in,
	input wire logic [7:0] s_axi_awaddr_in,
	input wire logic s_axi_awvalid_in,
	input wire logic s_axi_awready_out,
	input wire logic [31:0] s_axi_wdata_in,
	input wire logic s_axi_wvalid_in,
	input wire logic s_axi_wready_out,
	input wire logic s_axi_bvalid_out,
	input wire logic s_axi_bready_in,
	input wire logic [7:0] s_axi_araddr_in,
	input wire logic s_axi_arvalid_in,
	input wire logic s_axi_arready_out,
	input wire logic [1:0] s_axi_rresp_out,
	input wire logic s_axi_rvalid_out,
	input wire sdh_pkg::sdh_scsi_t scsi_bus_in,
	input wire logic dma_request_out,
	input wire logic dma_ready_out,
	input wire logic irq_out,
	input wire logic scsi_ack_out
);
	import sdh_pkg::*;
	default clocking cb @(posedge core_clk_in);
	endclocking
	default disable iff (reset_in);
	logic [7:0] wa_q, wd_q;
	logic dma_en_q, busy_en_q, enh_q;
	logic [2:0] req_hi_q;
	logic [5:0] bsy_lo_q;
	// capture address and data as each is taken
	always_ff @(posedge core_clk_in or posedge reset_in) begin
		if (reset_in) begin
			wa_q <= RST_BYTE;
			wd_q <= RST_BYTE;
		end else begin
			if (s_axi_awvalid_in && s_axi_awready_out) wa_q <= s_axi_awaddr_in;
			if (s_axi_wvalid_in && s_axi_wready_out) wd_q <= s_axi_wdata_in[7:0];
		end
	end
	// shadow mode bits, late by the write answer, so checks wait for idle bus
	always_ff @(posedge core_clk_in or posedge reset_in) begin
		if (reset_in) begin
			dma_en_q <= 1'b0;
			busy_en_q <= 1'b0;
			enh_q <= 1'b0;
		end else if (s_axi_bvalid_out && s_axi_bready_in) begin
			if (wa_q == OFS_MODE2) dma_en_q <= wd_q[MR2_DMA];
			if (wa_q == OFS_MODE2) busy_en_q <= wd_q[MR2_BUSY];
			if (wa_q == OFS_INIT_CMD) enh_q <= wd_q[ICR_ENH];
		end
	end
	// run lengths of a raised request and of a lost busy line
	always_ff @(posedge core_clk_in or posedge reset_in) begin
		if (reset_in) begin
			req_hi_q <= 3'h0;
			bsy_lo_q <= 6'h00;
		end else begin
			req_hi_q <= !scsi_bus_in.req ? 3'h0 : req_hi_q + {2'h0, req_hi_q != 3'h7};
			bsy_lo_q <= (scsi_bus_in.bsy || !busy_en_q || enh_q) ? 6'h00 :
				bsy_lo_q + {5'h0, bsy_lo_q != 6'h3f};
		end
	end
	chk_reset_clean: assert property ($fell(reset_in) |=> !irq_out && !dma_request_out)
		else $error("output active after reset");
	chk_dma_off_quiet: assert property (!dma_en_q && s_axi_awready_out
		|=> !dma_request_out && !dma_ready_out && !scsi_ack_out)
		else $error("dma output while dma disabled");
	chk_ack_holds: assert property (
		scsi_ack_out && req_hi_q == 3'h7 && s_axi_awready_out |=> scsi_ack_out)
		else $error("ack dropped while request high");
	chk_clear_read: assert property (!enh_q && !busy_en_q && s_axi_arvalid_in
		&& s_axi_arready_out && s_axi_araddr_in == OFS_HIGHEST |-> ##2 !irq_out)
		else $error("irq not cleared by read");
	chk_busy_loss: assert property (bsy_lo_q == 6'd60 |-> ##[0:8] irq_out)
		else $error("no irq on busy loss");
	chk_read_answer: assert property (s_axi_arvalid_in && s_axi_arready_out |=> s_axi_rvalid_out)
		else $error("read answer late");
	chk_write_answer: assert property (s_axi_awvalid_in && s_axi_awready_out
		&& s_axi_wvalid_in && s_axi_wready_out |=> ##1 s_axi_bvalid_out)
		else $error("write answer late");
	chk_unmapped_read: assert property (s_axi_arvalid_in && s_axi_arready_out
		&& s_axi_araddr_in > OFS_HIGHEST |=> s_axi_rresp_out == RESP_SLVERR)
		else $error("unmapped read not refused");
	cover property (bsy_lo_q == 6'd60);
	cover property (scsi_ack_out && req_hi_q == 3'h7);
	cover property ($rose(dma_request_out));
endmodule
bind sdh_core sdh_core_asserts #(.ARB_CYC(ARB_CYC)) u_sdh_asserts (
	.core_clk_in, .reset_in, .s_axi_awaddr_in, .s_axi_awvalid_in, .s_axi_awready_out,
	.s_axi_wdata_in, .s_axi_wvalid_in, .s_axi_wready_out, .s_axi_bvalid_out,
	.s_axi_bready_in, .s_axi_araddr_in, .s_axi_arvalid_in, .s_axi_arready_out,
	.s_axi_rresp_out, .s_axi_rvalid_out, .scsi_bus_in, .dma_request_out, .dma_ready_out,
	.irq_out, .scsi_ack_out
);
`default_nettype wire

// ### dv/sdh_dma_model.sv
// behavioural dma controller that answers the block's request line
`timescale 1ns/100ps
`default_nettype none
module sdh_dma_model (
	input wire logic core_clk_in,
	input wire logic reset_in,
	input wire logic run_in,
	input wire logic eop_in,
	input wire logic dma_request_in,
	output var sdh_pkg::sdh_dma_t dma_ctl_out
);
	import sdh_pkg::*;
	logic [2:0] cnt_q;
	logic act;
	// strobe four cycles, then rest three so a stale request is not answered twice
	assign act = (cnt_q > 3'h3) || (cnt_q == 3'h0 && run_in && dma_request_in);
	// strobe and rest counter
	always_ff @(posedge core_clk_in or posedge reset_in) begin
		if (reset_in) begin
			cnt_q <= 3'h0;
		end else if (cnt_q != 3'h0) begin
			cnt_q <= cnt_q - 3'h1;
		end else if (act) begin
			cnt_q <= 3'h6;
		end
	end
	// released data lines toggle, nothing holds them
	always_ff @(posedge core_clk_in or posedge reset_in) begin
		if (reset_in) begin
			dma_ctl_out <= '0;
		end else begin
			dma_ctl_out.dma_acknowledge <= act;
			dma_ctl_out.read_strobe <= act;
			dma_ctl_out.end_of_process <= act && eop_in;
			dma_ctl_out.data <= ~dma_ctl_out.data;
		end
	end
endmodule
`default_nettype wire

// ### inc/sdh_pkg.sv
// shared constants and types for the scsi dma halt and interrupt block
package sdh_pkg;
	// timing
	localparam int CLK_NS = 8;
	localparam int SETTLE_NS = 400;
	localparam int SETTLE_CYC = (SETTLE_NS + CLK_NS - 1) / CLK_NS;
	localparam int ARB_DLY_CYC = 300;
	// register byte offsets
	localparam logic [7:0] OFS_INIT_CMD = 8'h00;
	localparam logic [7:0] OFS_MODE2 = 8'h04;
	localparam logic [7:0] OFS_TPHASE = 8'h08;
	localparam logic [7:0] OFS_SEL_EN = 8'h0c;
	localparam logic [7:0] OFS_BUS_STAT = 8'h10;
	localparam logic [7:0] OFS_BUS_LINES = 8'h14;
	localparam logic [7:0] OFS_BUS_DATA = 8'h18;
	localparam logic [7:0] OFS_HIGHEST = 8'h1c;
	localparam logic [7:0] RST_BYTE = 8'h00;
	// field positions
	localparam int ICR_DBUS = 0;
	localparam int ICR_ENH = 6;
	localparam int MR2_DMA = 1;
	localparam int MR2_BUSY = 2;
	localparam int MR2_EOPI = 3;
	localparam int MR2_PINT = 4;
	localparam int MR2_PCHK = 5;
	localparam int MR2_BLK = 7;
	localparam int EMR_ARB = 0;
	localparam int EMR_HPPOL = 5;
	localparam int EMR_HPCHK = 6;
	localparam logic [1:0] EMR_IDX_ISR = 2'b11;
	localparam logic [1:0] EMR_IDX_CLR = 2'b01;
	localparam int HOST_PAR_BIT = 8;
	localparam logic [7:0] FLAG_MASKABLE = 8'hfe;
	// axi responses
	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;
	typedef enum logic [2:0] {
		DMA_IDLE = 3'b000,
		DMA_WAIT = 3'b001,
		DMA_XFER = 3'b010,
		DMA_END = 3'b011,
		DMA_HALT = 3'b100
	} sdh_dma_st_t;
	typedef enum logic [1:0] {
		ARB_OFF = 2'b00,
		ARB_FREE = 2'b01,
		ARB_RUN = 2'b10,
		ARB_DONE = 2'b11
	} sdh_arb_st_t;
	// scsi lines, active high after the pad inversion
	typedef struct packed {
		logic rst;
		logic bsy;
		logic req;
		logic msg;
		logic cd;
		logic io;
		logic sel;
		logic atn;
		logic ack;
		logic data_bus_parity_line;
		logic [7:0] data;
	} sdh_scsi_t;
	// dma controller lines, active high
	typedef struct packed {
		logic end_of_process;
		logic dma_acknowledge;
		logic read_strobe;
		logic write_strobe;
		logic par;
		logic [7:0] data;
	} sdh_dma_t;
endpackage

// ### verilog/sdh_core.sv
// scsi dma halt, ready control and interrupt logic behind an axi4-lite slave
//
// Chosen here: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/100ps
`default_nettype none
// Function
// - compatible block receive keeps ready inactive after end-of-process.
// - enhanced block mode returns ready active after the true end of dma.
// - phase mismatch in block mode leaves ready inactive.
// - compatible initiator holds ack after end-of-process; enhanced releases it itself.
// - dma request state readable in the bus and status register.
// - end-of-process flags end of dma or arms true end; dma bit untouched.
// - clearing the dma bit halts and resets all dma logic.
// - req with wrong phase during dma halts, stops data drive, interrupts.
// - enhanced dma mismatch sets its flag; mask suppresses flag and interrupt.
// - compatible read of highest address clears interrupt and parity status.
// - enhanced clear by writing index 01 then any other pattern.
// - enhanced events arriving in the same cycle as the clear are kept.
// - scsi parity errors set status; interrupt only when enabled.
// - enhanced host write parity check with selectable polarity.
// - end-of-process needs eop, acknowledge and a strobe together.
// - enhanced any phase mismatch on req sets flag unless masked.
// - busy inactive for settle delay interrupts; enhanced flag maskable.
// - selection detected on sel, no busy, and matching enabled id bit.
// - enhanced selection flag is maskable; host clears select enable first.
// - enhanced arbitration on bus free; flag always set, mask gates interrupt.
// - chip reset clears everything without interrupt or scsi reset.
// - enhanced mode follows the mode bit of the initiator command register.
// - enhanced index 11 steers next highest access to status or mask.
module sdh_core #(
	parameter int ARB_CYC = sdh_pkg::ARB_DLY_CYC
) (
	input wire logic core_clk_in,
	input wire logic reset_in,
	input wire logic [7:0] s_axi_awaddr_in,
	input wire logic s_axi_awvalid_in,
	output logic s_axi_awready_out,
	input wire logic [31:0] s_axi_wdata_in,
	input wire logic [3:0] s_axi_wstrb_in,
	input wire logic s_axi_wvalid_in,
	output logic s_axi_wready_out,
	output logic [1:0] s_axi_bresp_out,
	output logic s_axi_bvalid_out,
	input wire logic s_axi_bready_in,
	input wire logic [7:0] s_axi_araddr_in,
	input wire logic s_axi_arvalid_in,
	output logic s_axi_arready_out,
	output logic [31:0] s_axi_rdata_out,
	output logic [1:0] s_axi_rresp_out,
	output logic s_axi_rvalid_out,
	input wire logic s_axi_rready_in,
	input wire sdh_pkg::sdh_scsi_t scsi_bus_in,
	input wire sdh_pkg::sdh_dma_t dma_ctl_in,
	output logic dma_request_out,
	output logic dma_ready_out,
	output logic irq_out,
	output logic scsi_ack_out,
	output logic scsi_data_oe_out,
	output logic scsi_bsy_out,
	output logic scsi_sel_out
);
	import sdh_pkg::*;

	localparam logic [15:0] ARB_LAST = 16'(ARB_CYC - 1);
	localparam logic [7:0] SETTLE_LAST = 8'(SETTLE_CYC);

	// ==========================================================
	// helpers
	function automatic logic mapped(input logic [7:0] a);
		return (a[1:0] == 2'b00) && (a <= OFS_HIGHEST);
	endfunction

	function automatic logic eop_cond(input sdh_dma_t d);
		return d.end_of_process & d.dma_acknowledge & (d.read_strobe | d.write_strobe);
	endfunction

	// odd parity over data and parity line
	function automatic logic scsi_par_bad(input sdh_scsi_t s);
		return ~(^{s.data, s.data_bus_parity_line});
	endfunction

	// ==========================================================
	// declarations
	sdh_scsi_t s1_q, s2_q, s3_q;
	sdh_dma_t d1_q, d2_q, d3_q;
	logic [7:0] icr_q, mr2_q, tcr_q, ser_q, emr_q, imr_q, isr_q, isr_d;
	logic idx_armed_q, clr_armed_q, spar_q, busy_err_q, end_dma_flag_q, sel_prev_q;
	logic awready_q, wready_q, bvalid_q, arready_q, rvalid_q, irq_q;
	logic aw_hold_q, w_hold_q, aw_hold_d, w_hold_d, bvalid_d, rvalid_d;
	logic [7:0] aw_addr_q;
	logic [8:0] w_data_q;
	logic [1:0] bresp_q, rresp_q;
	logic [7:0] rdata_q, rd_byte;
	logic rd_ok;
	logic aw_take, w_take, ar_take, wr_go, wr_hi, rd_hi;
	logic enh, blk, dma_on, mism, req_rise, stb_rise, eop_rise, true_end;
	logic sel_cond, sel_ev, spar_ev, hpar_ev, busy_ev, arb_ev, clr_ev;
	logic [7:0] ev, imask;
	sdh_dma_st_t dma_st_q;
	logic drq_q, rdy_q, ack_q, oe_q, eop_seen_q;
	sdh_arb_st_t arb_st_q;
	logic arb_bsy_q, arb_sel_q;
	logic [15:0] arb_cnt_q;
	logic [7:0] idle_cnt_q, free_cnt_q;

	// ==========================================================
	// pin synchronisers; the second stage feeds logic, the third only edge detection
	always_ff @(posedge core_clk_in or posedge reset_in) begin
		if (reset_in) begin
			s1_q <= '0;
			s2_q <= '0;
			s3_q <= '0;
			d1_q <= '0;
			d2_q <= '0;
			d3_q <= '0;
		end else begin
			s1_q <= scsi_bus_in;
			s2_q <= s1_q;
			s3_q <= s2_q;
			d1_q <= dma_ctl_in;
			d2_q <= d1_q;
			d3_q <= d2_q;
		end
	end

	// ==========================================================
	// decoded conditions
	always_comb begin
		enh = icr_q[ICR_ENH];
		blk = mr2_q[MR2_BLK];
		dma_on = mr2_q[MR2_DMA];
		mism = tcr_q[2:0] != {s2_q.msg, s2_q.cd, s2_q.io};
		req_rise = s2_q.req & ~s3_q.req;
		stb_rise = (d2_q.dma_acknowledge & (d2_q.read_strobe | d2_q.write_strobe))
			& ~(d3_q.dma_acknowledge & (d3_q.read_strobe | d3_q.write_strobe));
		eop_rise = dma_on && eop_cond(d2_q) && !eop_cond(d3_q);
		true_end = enh && dma_st_q == DMA_XFER && !s2_q.req && eop_seen_q;
		sel_cond = s2_q.sel & ~s2_q.bsy & (|(ser_q & s2_q.data));
		sel_ev = sel_cond & ~sel_prev_q;
	end

	// ==========================================================
	// axi4-lite handshakes: one write and one read in flight
	always_comb begin
		aw_take = s_axi_awvalid_in & awready_q;
		w_take = s_axi_wvalid_in & wready_q;
		wr_go = aw_hold_q & w_hold_q & ~bvalid_q;
		aw_hold_d = (aw_hold_q | aw_take) & ~wr_go;
		w_hold_d = (w_hold_q | w_take) & ~wr_go;
		bvalid_d = wr_go | (bvalid_q & ~s_axi_bready_in);
		ar_take = s_axi_arvalid_in & arready_q;
		rvalid_d = ar_take | (rvalid_q & ~s_axi_rready_in);
		wr_hi = wr_go && aw_addr_q == OFS_HIGHEST;
		rd_hi = ar_take && s_axi_araddr_in == OFS_HIGHEST;
	end

	always_ff @(posedge core_clk_in or posedge reset_in) begin
		if (reset_in) begin
			aw_hold_q <= 1'b0;
			w_hold_q <= 1'b0;
			awready_q <= 1'b0;
			wready_q <= 1'b0;
			bvalid_q <= 1'b0;
			bresp_q <= RESP_OKAY;
			aw_addr_q <= RST_BYTE;
			w_data_q <= 9'h000;
		end else begin
			aw_hold_q <= aw_hold_d;
			w_hold_q <= w_hold_d;
			awready_q <= ~aw_hold_d & ~bvalid_d;
			wready_q <= ~w_hold_d & ~bvalid_d;
			bvalid_q <= bvalid_d;
			if (aw_take) begin
				aw_addr_q <= s_axi_awaddr_in;
			end
			if (w_take) begin
				w_data_q <= s_axi_wdata_in[8:0];
			end
			if (wr_go) begin
				bresp_q <= mapped(aw_addr_q) ? RESP_OKAY : RESP_SLVERR;
			end
		end
	end

	// read mux; reads of unmapped words answer slverr with zero data
	always_comb begin
		rd_byte = 8'h00;
		rd_ok = mapped(s_axi_araddr_in);
		case (s_axi_araddr_in)
			OFS_INIT_CMD: rd_byte = icr_q;
			OFS_MODE2: rd_byte = mr2_q;
			OFS_TPHASE: rd_byte = tcr_q;
			OFS_BUS_STAT: rd_byte = {end_dma_flag_q, drq_q, spar_q, irq_q, ~mism, busy_err_q,
				s2_q.atn, s2_q.ack};
			OFS_BUS_LINES: rd_byte = {s2_q.rst, s2_q.bsy, s2_q.req, s2_q.msg, s2_q.cd,
				s2_q.io, s2_q.sel, s2_q.data_bus_parity_line};
			OFS_BUS_DATA: rd_byte = s2_q.data;
			OFS_HIGHEST: rd_byte = !enh ? 8'h00 : (idx_armed_q ? isr_q : emr_q);
			default: rd_byte = 8'h00;
		endcase
	end

	always_ff @(posedge core_clk_in or posedge reset_in) begin
		if (reset_in) begin
			arready_q <= 1'b0;
			rvalid_q <= 1'b0;
			rdata_q <= RST_BYTE;
			rresp_q <= RESP_OKAY;
		end else begin
			arready_q <= ~rvalid_d;
			rvalid_q <= rvalid_d;
			if (ar_take) begin
				rdata_q <= rd_byte;
				rresp_q <= rd_ok ? RESP_OKAY : RESP_SLVERR;
			end
		end
	end

	// ==========================================================
	// software registers; a full wipe on reset, no interrupt follows
	always_ff @(posedge core_clk_in or posedge reset_in) begin
		if (reset_in) begin
			icr_q <= RST_BYTE;
			mr2_q <= RST_BYTE;
			tcr_q <= RST_BYTE;
			ser_q <= RST_BYTE;
			emr_q <= RST_BYTE;
			imr_q <= RST_BYTE;
			idx_armed_q <= 1'b0;
			clr_armed_q <= 1'b0;
		end else begin
			// dma bit only moves by software, never by end-of-process
			if (wr_go) begin
				case (aw_addr_q)
					OFS_INIT_CMD: icr_q <= w_data_q[7:0];
					OFS_MODE2: mr2_q <= w_data_q[7:0];
					OFS_TPHASE: tcr_q <= w_data_q[7:0];
					OFS_SEL_EN: ser_q <= w_data_q[7:0];
					default: ;
				endcase
			end
			if (wr_hi && enh && idx_armed_q) begin
				imr_q <= w_data_q[7:0];
				idx_armed_q <= 1'b0;
			end else if (wr_hi && enh) begin
				emr_q <= w_data_q[7:0];
				idx_armed_q <= w_data_q[2:1] == EMR_IDX_ISR;
				clr_armed_q <= w_data_q[2:1] == EMR_IDX_CLR;
			end else if (rd_hi && enh) begin
				idx_armed_q <= 1'b0;
			end
		end
	end

	// ==========================================================
	// event sources
	always_comb begin
		clr_ev = (rd_hi && !enh)
			|| (wr_hi && enh && !idx_armed_q && clr_armed_q
			&& w_data_q[2:1] != EMR_IDX_CLR);
		spar_ev = mr2_q[MR2_PCHK] && scsi_par_bad(s2_q) && (sel_ev
			|| (ar_take && s_axi_araddr_in == OFS_BUS_DATA)
			|| (dma_on && stb_rise && d2_q.read_strobe));
		hpar_ev = enh && emr_q[EMR_HPCHK]
			&& ((wr_go && ((^w_data_q) != emr_q[EMR_HPPOL]))
			|| (dma_on && stb_rise && d2_q.write_strobe
			&& ((^{d2_q.data, d2_q.par}) != emr_q[EMR_HPPOL])));
		busy_ev = mr2_q[MR2_BUSY] && idle_cnt_q == SETTLE_LAST - 8'h01;
		arb_ev = arb_st_q == ARB_RUN && (arb_cnt_q == ARB_LAST || s2_q.sel);
		ev[7] = spar_ev & mr2_q[MR2_PINT];
		ev[6] = hpar_ev;
		ev[5] = (enh ? true_end : eop_rise) & mr2_q[MR2_EOPI];
		ev[4] = dma_on && dma_st_q == DMA_WAIT && req_rise && mism;
		ev[3] = enh && req_rise && mism;
		ev[2] = busy_ev;
		ev[1] = sel_ev;
		ev[0] = enh && arb_ev;
		// arbitration flag is never suppressed, only its interrupt
		imask = enh ? imr_q : 8'h00;
		isr_d = (clr_ev ? 8'h00 : isr_q) | (ev & ~(imask & FLAG_MASKABLE));
	end

	// pending flags and interrupt line; a new event beats a clear
	always_ff @(posedge core_clk_in or posedge reset_in) begin
		if (reset_in) begin
			isr_q <= RST_BYTE;
			irq_q <= 1'b0;
			spar_q <= 1'b0;
			busy_err_q <= 1'b0;
			sel_prev_q <= 1'b0;
		end else begin
			isr_q <= isr_d;
			irq_q <= |(isr_q & ~imask);
			spar_q <= (spar_q & ~clr_ev) | spar_ev;
			busy_err_q <= (busy_err_q & ~clr_ev) | busy_ev;
			sel_prev_q <= sel_cond;
		end
	end

	// ==========================================================
	// settle counters for busy loss and bus free
	always_ff @(posedge core_clk_in or posedge reset_in) begin
		if (reset_in) begin
			idle_cnt_q <= 8'h00;
			free_cnt_q <= 8'h00;
		end else begin
			// saturate so busy loss fires once per idle stretch
			if (s2_q.bsy) begin
				idle_cnt_q <= 8'h00;
			end else if (idle_cnt_q != SETTLE_LAST) begin
				idle_cnt_q <= idle_cnt_q + 8'h01;
			end
			if (s2_q.bsy || s2_q.sel) begin
				free_cnt_q <= 8'h00;
			end else if (free_cnt_q != SETTLE_LAST) begin
				free_cnt_q <= free_cnt_q + 8'h01;
			end
		end
	end

	// ==========================================================
	// dma engine: request, ready, ack and halting
	always_ff @(posedge core_clk_in or posedge reset_in) begin
		if (reset_in) begin
			dma_st_q <= DMA_IDLE;
			drq_q <= 1'b0;
			rdy_q <= 1'b0;
			ack_q <= 1'b0;
			oe_q <= 1'b0;
			eop_seen_q <= 1'b0;
			end_dma_flag_q <= 1'b0;
		end else if (!dma_on) begin
			dma_st_q <= DMA_IDLE;
			drq_q <= 1'b0;
			rdy_q <= 1'b0;
			ack_q <= 1'b0;
			oe_q <= 1'b0;
			eop_seen_q <= 1'b0;
			end_dma_flag_q <= 1'b0;
		end else begin
			case (dma_st_q)
				DMA_IDLE: begin
					dma_st_q <= DMA_WAIT;
					drq_q <= blk;
					oe_q <= icr_q[ICR_DBUS];
				end
				DMA_WAIT: begin
					if (req_rise && mism) begin
						dma_st_q <= DMA_HALT;
						drq_q <= 1'b0;
						rdy_q <= 1'b0;
						oe_q <= 1'b0;
					end else if (stb_rise) begin
						drq_q <= 1'b0;
						rdy_q <= 1'b0;
						ack_q <= 1'b1;
						dma_st_q <= DMA_XFER;
					end else if (req_rise) begin
						// block mode requests once, then paces bytes with ready
						drq_q <= ~blk;
						rdy_q <= blk;
					end else if (blk && d2_q.dma_acknowledge) begin
						drq_q <= 1'b0;
					end
				end
				DMA_XFER: begin
					if (!s2_q.req && eop_seen_q) begin
						dma_st_q <= DMA_END;
						// compatible mode keeps ack and leaves ready low
						ack_q <= ~enh;
						rdy_q <= enh & blk;
					end else if (!s2_q.req) begin
						ack_q <= 1'b0;
						dma_st_q <= DMA_WAIT;
					end
				end
				DMA_END: dma_st_q <= DMA_END;
				DMA_HALT: dma_st_q <= DMA_HALT;
				default: dma_st_q <= DMA_IDLE;
			endcase
			if (eop_rise) begin
				eop_seen_q <= 1'b1;
			end
			if (enh ? true_end : eop_rise) begin
				end_dma_flag_q <= 1'b1;
			end
		end
	end

	// ==========================================================
	// automatic arbitration, enhanced mode only
	always_ff @(posedge core_clk_in or posedge reset_in) begin
		if (reset_in) begin
			arb_st_q <= ARB_OFF;
			arb_bsy_q <= 1'b0;
			arb_sel_q <= 1'b0;
			arb_cnt_q <= 16'h0000;
		end else begin
			case (arb_st_q)
				ARB_OFF: begin
					arb_bsy_q <= 1'b0;
					arb_sel_q <= 1'b0;
					if (enh && emr_q[EMR_ARB]) begin
						arb_st_q <= ARB_FREE;
					end
				end
				ARB_FREE: begin
					if (!emr_q[EMR_ARB]) begin
						arb_st_q <= ARB_OFF;
					end else if (free_cnt_q == SETTLE_LAST) begin
						arb_st_q <= ARB_RUN;
						arb_bsy_q <= 1'b1;
						arb_cnt_q <= 16'h0000;
					end
				end
				ARB_RUN: begin
					arb_cnt_q <= arb_cnt_q + 16'h0001;
					if (arb_ev) begin
						arb_st_q <= ARB_DONE;
						// won when no higher id shows on the data bus
						arb_sel_q <= !s2_q.sel && ((s2_q.data
							& ~8'((({1'b0, ser_q}) << 1) - 9'h001)) == 8'h00);
						arb_bsy_q <= !s2_q.sel && ((s2_q.data
							& ~8'((({1'b0, ser_q}) << 1) - 9'h001)) == 8'h00);
					end
				end
				ARB_DONE: begin
					if (!emr_q[EMR_ARB]) begin
						arb_st_q <= ARB_OFF;
					end
				end
				default: arb_st_q <= ARB_OFF;
			endcase
		end
	end

	// ==========================================================
	// outputs straight from flops
	assign s_axi_awready_out = awready_q;
	assign s_axi_wready_out = wready_q;
	assign s_axi_bvalid_out = bvalid_q;
	assign s_axi_bresp_out = bresp_q;
	assign s_axi_arready_out = arready_q;
	assign s_axi_rvalid_out = rvalid_q;
	assign s_axi_rresp_out = rresp_q;
	assign s_axi_rdata_out = {24'h000000, rdata_q};
	assign dma_request_out = drq_q;
	assign dma_ready_out = rdy_q;
	assign irq_out = irq_q;
	assign scsi_ack_out = ack_q;
	assign scsi_data_oe_out = oe_q;
	assign scsi_bsy_out = arb_bsy_q;
	assign scsi_sel_out = arb_sel_q;
endmodule
`default_nettype wire
